// file: rfc_core.v
// Protocol settings and debug route command engine with Avalon-MM slave
//
// Functional notes
// - Patch carries one to forty-two six-byte entries
// - Patch selector in 00-1C or 80-9C
// - Patch address must exist in configuration
// - Violated constraint raises exception, skips operation; the code ignores out-of-range route pin bytes without an exception
// - Multi-byte payload fields travel LSB first
// - Count query returns configuration register count
// - Query and read selectors share range
// - Read returns up to 39 address-content pairs
// - Code 15 reserved, no parameter, no answer
// - Field on: bit0 no-CA, bit1 active
// - Field on sets up flag if enabled
// - Field off ignores its dummy byte
// - Field off sets down flag if enabled
// - Route: group byte, one to four pin bytes
// - Debug pins show only when allow set
// - Low nibble 0-7 signal, 8 clock
// - High nibble picks pin 0-3
// - All four pins drive simultaneously
// - Group byte decodes seven signal groups
// - Clock group order of eight signals
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`include "rfc_regs.vh"
module rfc_core #(
  parameter AW = 6
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire [7:0]  clk_group_sig,
  input  wire [7:0]  txenc_sig,
  input  wire [7:0]  timer_sig,
  input  wire [7:0]  card_sig,
  input  wire [7:0]  trx_sig,
  input  wire [7:0]  rxdata_sig,
  input  wire [7:0]  rxerr_sig,
  input  wire        rf_clk_div,
  input  wire        irq_func,
  input  wire        aux_pin_one_func,
  input  wire        aux_pin_two_func,
  input  wire        gpo_func,
  output reg         irq_pin,
  output reg         aux_pin_one,
  output reg         aux_pin_two,
  output reg         general_output_pin,
  output reg         field_on,
  output reg         no_collision_avoid,
  output reg         active_mode
);
  localparam S_IDLE = 6'b000001;
  localparam S_ARG  = 6'b000010;
  localparam S_WR   = 6'b000100;
  localparam S_RD   = 6'b001000;
  localparam S_RDW  = 6'b010000;
  localparam S_DONE = 6'b100000;
  reg  [5:0]  state_reg;
  reg  [7:0]  op_reg;
  reg  [7:0]  sel_reg;
  reg  [5:0]  cnt_reg;
  reg  [2:0]  byte_reg;
  reg  [7:0]  addr_reg;
  reg  [31:0] val_reg;
  reg  [5:0]  rd_idx_reg;
  reg  [7:0]  route_grp_reg;
  reg  [2:0]  route_n_reg;
  reg  [7:0]  pin_cfg_reg [0:3];
  reg         exc_reg;
  reg         up_reg;
  reg         down_reg;
  reg  [2:0]  allow_reg;
  reg  [31:0] rd_data_reg;
  reg         rd_valid_reg;
  reg  [AW:0] size_reg [0:63];
  wire [7:0]  grp_sig [0:3];
  wire [3:0]  dbg_val;
  wire [31:0] st_rdata;
  wire [7:0]  cs_s;
  wire [7:0]  tx_s;
  wire [7:0]  tm_s;
  wire [7:0]  cm_s;
  wire [7:0]  tr_s;
  wire [7:0]  rd_s;
  wire [7:0]  re_s;
  wire [3:0]  func_s;
  reg  [5:0]  cfg_idx;
  reg         sel_ok;
  // Writes and read side effects act at the edge that completes the transfer
  wire        wr_acc = avs_write && !avs_waitrequest;
  wire        rd_acc = avs_read && avs_waitrequest;
  wire [7:0]  wb = avs_writedata[7:0];
  wire        cmd_wr = wr_acc && avs_address == `RFC_ADDR_CMD;
  wire        dat_wr = wr_acc && avs_address == `RFC_ADDR_DATA;
  wire        dat_rd = avs_read && !avs_waitrequest && avs_address == `RFC_ADDR_DATA;
  integer     k;
  integer     j;
  genvar      g;

  rfc_sync #(.W(8)) u_s0 (.clk_sys(clk_sys), .rst(rst), .din(clk_group_sig), .dout(cs_s));
  rfc_sync #(.W(8)) u_s1 (.clk_sys(clk_sys), .rst(rst), .din(txenc_sig), .dout(tx_s));
  rfc_sync #(.W(8)) u_s2 (.clk_sys(clk_sys), .rst(rst), .din(timer_sig), .dout(tm_s));
  rfc_sync #(.W(8)) u_s3 (.clk_sys(clk_sys), .rst(rst), .din(card_sig), .dout(cm_s));
  rfc_sync #(.W(8)) u_s4 (.clk_sys(clk_sys), .rst(rst), .din(trx_sig), .dout(tr_s));
  rfc_sync #(.W(8)) u_s5 (.clk_sys(clk_sys), .rst(rst), .din(rxdata_sig), .dout(rd_s));
  rfc_sync #(.W(8)) u_s6 (.clk_sys(clk_sys), .rst(rst), .din(rxerr_sig), .dout(re_s));
  rfc_sync #(.W(4)) u_s7 (.clk_sys(clk_sys), .rst(rst),
                          .din({gpo_func, aux_pin_two_func, aux_pin_one_func, irq_func}), .dout(func_s));

  // Selector validity and index: 0..28 transmit, 29..57 receive
  always @* begin
    sel_ok  = (sel_reg <= `RFC_SEL_TX_MAX) ||
              (sel_reg >= `RFC_SEL_RX_MIN && sel_reg <= `RFC_SEL_RX_MAX);
    cfg_idx = sel_reg[`RFC_SEL_RX_BIT] ? (sel_reg[5:0] + 6'd29) : sel_reg[5:0];
  end

  rfc_store #(.AW(AW)) u_store (
    .clk_sys (clk_sys),
    .cfg     (cfg_idx),
    .addr    (state_reg == S_WR ? addr_reg[AW-1:0] : rd_idx_reg[AW-1:0]),
    .we      (state_reg == S_WR),
    .wdata   (val_reg),
    .rdata   (st_rdata)
  );

  // Command sequencer
  always @(posedge clk_sys) begin
    if (rst) begin
      state_reg     <= S_IDLE;
      op_reg        <= 8'h00;
      sel_reg       <= 8'h00;
      cnt_reg       <= 6'd0;
      byte_reg      <= 3'd0;
      addr_reg      <= 8'h00;
      val_reg       <= 32'h0000_0000;
      rd_idx_reg    <= 6'd0;
      route_grp_reg <= 8'h00;
      route_n_reg   <= 3'd0;
      exc_reg       <= 1'b0;
      up_reg        <= 1'b0;
      down_reg      <= 1'b0;
      field_on      <= 1'b0;
      no_collision_avoid <= 1'b0;
      active_mode   <= 1'b0;
      rd_data_reg   <= 32'h0000_0000;
      rd_valid_reg  <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        pin_cfg_reg[k] <= 8'h00;
      end
    end else begin
      if (dat_rd) begin
        rd_valid_reg <= 1'b0;
      end
      if (wr_acc && avs_address == `RFC_ADDR_STATUS) begin
        exc_reg  <= exc_reg & ~avs_writedata[`RFC_ST_EXC];
        up_reg   <= up_reg & ~avs_writedata[`RFC_ST_UP];
        down_reg <= down_reg & ~avs_writedata[`RFC_ST_DOWN];
      end
      case (state_reg)
        S_IDLE: begin
          if (cmd_wr) begin
            op_reg      <= wb;
            cnt_reg     <= 6'd0;
            byte_reg    <= 3'd0;
            route_n_reg <= 3'd0;
            if (wb != `RFC_OP_RFU) begin
              state_reg <= S_ARG;
            end
          end
        end
        S_ARG: begin
          if (cmd_wr) begin
            // Terminates variable-length patch and route commands
            if (op_reg == `RFC_OP_PATCH && (cnt_reg == 6'd0 || byte_reg != 3'd0)) begin
              exc_reg <= 1'b1;
            end
            if (op_reg == `RFC_OP_ROUTE && route_n_reg == 3'd0) begin
              exc_reg <= 1'b1;
            end
            state_reg <= S_IDLE;
          end else if (dat_wr) begin
            case (op_reg)
              `RFC_OP_PATCH: begin
                byte_reg <= (byte_reg == 3'd5) ? 3'd0 : byte_reg + 3'd1;
                case (byte_reg)
                  3'd0: sel_reg <= wb;
                  3'd1: addr_reg <= wb;
                  3'd2: val_reg[7:0] <= wb;
                  3'd3: val_reg[15:8] <= wb;
                  3'd4: val_reg[23:16] <= wb;
                  default: begin
                    val_reg[31:24] <= wb;
                    if (!sel_ok || cnt_reg == `RFC_PATCH_MAX ||
                        addr_reg >= {{(7-AW){1'b0}}, size_reg[cfg_idx]}) begin
                      exc_reg   <= 1'b1;
                      state_reg <= S_DONE;
                    end else begin
                      cnt_reg   <= cnt_reg + 6'd1;
                      state_reg <= S_WR;
                    end
                  end
                endcase
              end
              `RFC_OP_COUNT, `RFC_OP_READ: begin
                sel_reg   <= wb;
                state_reg <= S_DONE;
                if (!((wb <= `RFC_SEL_TX_MAX) ||
                      (wb >= `RFC_SEL_RX_MIN && wb <= `RFC_SEL_RX_MAX))) begin
                  exc_reg <= 1'b1;
                end else if (op_reg == `RFC_OP_COUNT) begin
                  rd_data_reg  <= 32'h0;
                  state_reg    <= S_RD;
                end else begin
                  rd_idx_reg   <= 6'd0;
                  state_reg    <= S_RD;
                end
              end
              `RFC_OP_FIELD_ON: begin
                field_on           <= 1'b1;
                no_collision_avoid <= wb[`RFC_ONB_NOCA];
                active_mode        <= wb[`RFC_ONB_ACTIVE];
                if (allow_reg[`RFC_ALLOW_IRQ_UP]) begin
                  up_reg <= 1'b1;
                end
                state_reg <= S_DONE;
              end
              `RFC_OP_FIELD_OFF: begin
                field_on <= 1'b0;
                if (allow_reg[`RFC_ALLOW_IRQ_DOWN]) begin
                  down_reg <= 1'b1;
                end
                state_reg <= S_DONE;
              end
              `RFC_OP_ROUTE: begin
                if (byte_reg == 3'd0) begin
                  route_grp_reg <= wb;
                  byte_reg      <= 3'd1;
                end else if (route_n_reg == 3'd4) begin
                  exc_reg   <= 1'b1;
                  state_reg <= S_DONE;
                end else begin
                  route_n_reg <= route_n_reg + 3'd1;
                  if (wb[7:4] <= `RFC_PIN_MAX && wb[3:0] <= `RFC_SIG_CLK) begin
                    pin_cfg_reg[wb[5:4]] <= {route_grp_reg[6:0] == 7'h0 ? 4'h0 : 4'h1, wb[3:0]};
                  end
                end
              end
              default: state_reg <= S_DONE;
            endcase
          end
        end
        S_WR: begin
          state_reg <= S_ARG;
        end
        S_RD: begin
          state_reg <= S_RDW;
        end
        S_RDW: begin
          if (op_reg == `RFC_OP_COUNT) begin
            rd_data_reg  <= {{(31-AW){1'b0}}, size_reg[cfg_idx]};
            rd_valid_reg <= 1'b1;
            state_reg    <= S_DONE;
          end else if (rd_idx_reg >= `RFC_READ_MAX ||
                       {1'b0, rd_idx_reg} >= {{(6-AW){1'b0}}, size_reg[cfg_idx]}) begin
            state_reg <= S_DONE;
          end else if (!rd_valid_reg) begin
            // Address in bits 7:0, content LSB first in bits 39:8 over two words
            rd_data_reg  <= {st_rdata[23:0], 2'b00, rd_idx_reg};
            val_reg      <= {24'h0, st_rdata[31:24]};
            rd_valid_reg <= 1'b1;
            byte_reg     <= 3'd1;
          end else if (dat_rd && byte_reg == 3'd1) begin
            rd_data_reg  <= val_reg;
            rd_valid_reg <= 1'b1;
            byte_reg     <= 3'd0;
            rd_idx_reg   <= rd_idx_reg + 6'd1;
            state_reg    <= S_RD;
          end
        end
        default: begin
          // A failed list still waits for its closing command write
          if (cmd_wr || (!rd_valid_reg && op_reg != `RFC_OP_PATCH && op_reg != `RFC_OP_ROUTE)) begin
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Size table: loaded by software, one word per configuration
  always @(posedge clk_sys) begin
    if (rst) begin
      for (j = 0; j < 64; j = j + 1) begin
        size_reg[j] <= {(AW+1){1'b0}};
      end
    end else if (wr_acc && avs_address == `RFC_ADDR_SIZES) begin
      size_reg[avs_writedata[13:8]] <= avs_writedata[AW:0];
    end
  end

  // Group decode from the one shared route group register, signal select per pin
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pin
      assign grp_sig[g] = (route_grp_reg == `RFC_GRP_CLOCK)  ? cs_s :
                          (route_grp_reg == `RFC_GRP_TXENC)  ? tx_s :
                          (route_grp_reg == `RFC_GRP_TIMER)  ? tm_s :
                          (route_grp_reg == `RFC_GRP_CARD)   ? cm_s :
                          (route_grp_reg == `RFC_GRP_TRX)    ? tr_s :
                          (route_grp_reg == `RFC_GRP_RXDATA) ? rd_s :
                          (route_grp_reg == `RFC_GRP_RXERR)  ? re_s : 8'h00;
      assign dbg_val[g] = !pin_cfg_reg[g][4] ? func_s[g] :
                          (pin_cfg_reg[g][3:0] == `RFC_SIG_CLK) ? rf_clk_div :
                          grp_sig[g][pin_cfg_reg[g][2:0]];
    end
  endgenerate

  // Pins and bus answer
  always @(posedge clk_sys) begin
    if (rst) begin
      irq_pin            <= 1'b0;
      aux_pin_one        <= 1'b0;
      aux_pin_two        <= 1'b0;
      general_output_pin <= 1'b0;
      allow_reg          <= 3'b000;
      avs_readdata       <= 32'h0000_0000;
      avs_waitrequest    <= 1'b1;
    end else begin
      if (allow_reg[`RFC_ALLOW_OUT]) begin
        irq_pin            <= dbg_val[0];
        aux_pin_one        <= dbg_val[1];
        aux_pin_two        <= dbg_val[2];
        general_output_pin <= dbg_val[3];
      end else begin
        irq_pin            <= func_s[0];
        aux_pin_one        <= func_s[1];
        aux_pin_two        <= func_s[2];
        general_output_pin <= func_s[3];
      end
      if (wr_acc && avs_address == `RFC_ADDR_ALLOW) begin
        allow_reg <= avs_writedata[2:0];
      end
      avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
      if (rd_acc) begin
        case (avs_address)
          `RFC_ADDR_DATA:   avs_readdata <= rd_data_reg;
          `RFC_ADDR_STATUS: avs_readdata <= {26'h0, field_on, down_reg, up_reg, rd_valid_reg,
                                             state_reg != S_IDLE, exc_reg};
          `RFC_ADDR_FIELD:  avs_readdata <= {29'h0, active_mode, no_collision_avoid, field_on};
          `RFC_ADDR_ALLOW:  avs_readdata <= {29'h0, allow_reg};
          default:          avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // rfc_core

// file: rfc_regs.vh
// Constants for the protocol settings and debug route command engine
`ifndef RFC_REGS_VH
`define RFC_REGS_VH
`define RFC_ADDR_CMD       4'h0
`define RFC_ADDR_DATA      4'h1
`define RFC_ADDR_STATUS    4'h2
`define RFC_ADDR_FIELD     4'h3
`define RFC_ADDR_ALLOW     4'h4
`define RFC_ADDR_SIZES     4'h5
`define RFC_OP_PATCH       8'h12
`define RFC_OP_COUNT       8'h13
`define RFC_OP_READ        8'h14
`define RFC_OP_RFU         8'h15
`define RFC_OP_FIELD_ON    8'h16
`define RFC_OP_FIELD_OFF   8'h17
`define RFC_OP_ROUTE       8'h18
`define RFC_SEL_TX_MAX     8'h1C
`define RFC_SEL_RX_MIN     8'h80
`define RFC_SEL_RX_MAX     8'h9C
`define RFC_SEL_RX_BIT     7
`define RFC_PATCH_MAX      6'd42
`define RFC_READ_MAX       6'd39
`define RFC_GRP_CLOCK      8'h01
`define RFC_GRP_TXENC      8'h1B
`define RFC_GRP_TIMER      8'h1D
`define RFC_GRP_CARD       8'h30
`define RFC_GRP_TRX        8'h58
`define RFC_GRP_RXDATA     8'h70
`define RFC_GRP_RXERR      8'h73
`define RFC_SIG_CLK        4'h8
`define RFC_PIN_MAX        4'h3
`define RFC_ONB_NOCA       0
`define RFC_ONB_ACTIVE     1
`define RFC_ST_EXC         0
`define RFC_ST_BUSY        1
`define RFC_ST_RDV         2
`define RFC_ST_UP          3
`define RFC_ST_DOWN        4
`define RFC_ST_FIELD       5
`define RFC_ALLOW_OUT      0
`define RFC_ALLOW_IRQ_UP   1
`define RFC_ALLOW_IRQ_DOWN 2
`endif

// file: rfc_sync.v
// Three flop synchroniser with agreement of the last two stages
`timescale 1ns/1ns
module rfc_sync #(
  parameter W = 8
) (
  input  wire         clk_sys,
  input  wire         rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  genvar i;
  always @(posedge clk_sys) begin
    if (rst) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk_sys) begin
        if (rst) begin
          dout[i] <= 1'b0;
        end else if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule // rfc_sync

// file: rfc_store.v
// Settings memory: 64 configurations of 64 words, one word per register
`timescale 1ns/1ns
module rfc_store #(
  parameter AW = 6
) (
  input  wire          clk_sys,
  input  wire [5:0]    cfg,
  input  wire [AW-1:0] addr,
  input  wire          we,
  input  wire [31:0]   wdata,
  output reg  [31:0]   rdata
);
  reg [31:0] mem_reg [0:(64<<AW)-1];
  always @(posedge clk_sys) begin
    if (we) begin
      mem_reg[{cfg, addr}] <= wdata;
    end
    rdata <= mem_reg[{cfg, addr}];
  end
endmodule // rfc_store

// file: rfc_core_assertions.sv
// Port checker for the settings and debug route engine
`timescale 1ns/1ns
module rfc_core_chk #(
  parameter AW = 6
) (
  input wire        clk_sys,
  input wire        rst,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        field_on,
  input wire        no_collision_avoid,
  input wire        active_mode
);
  reg  [7:0] op_reg;
  reg  [7:0] par_reg;
  wire       acc = avs_write && !avs_waitrequest;
  // Last opcode and parameter byte accepted
  always @(posedge clk_sys) begin
    if (rst) begin
      op_reg  <= 8'h00;
      par_reg <= 8'h00;
    end else if (acc && avs_address == 4'h0) begin
      op_reg <= avs_writedata[7:0];
    end else if (acc && avs_address == 4'h1) begin
      par_reg <= avs_writedata[7:0];
    end
  end
  property p_ack;
    @(posedge clk_sys) disable iff (rst) (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered after one wait state");
  property p_ack_one;
    @(posedge clk_sys) disable iff (rst) !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("waitrequest low for more than one cycle");
  property p_fell_cause;
    @(posedge clk_sys) disable iff (rst) $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
  endproperty
  a_fell_cause: assert property (p_fell_cause) else $error("answer without request");
  property p_rst;
    @(posedge clk_sys) rst |=> avs_waitrequest && !field_on && !no_collision_avoid && !active_mode;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset values");
  property p_unmapped;
    @(posedge clk_sys) disable iff (rst) avs_read && !avs_waitrequest && avs_address > 4'h5 |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    @(posedge clk_sys) disable iff (rst) !avs_read |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");
  property p_on;
    @(posedge clk_sys) disable iff (rst) acc && avs_address == 4'h1 && op_reg == 8'h16
      |=> ##[0:7] (field_on && no_collision_avoid == par_reg[0] && active_mode == par_reg[1]);
  endproperty
  a_on: assert property (p_on) else $error("field on levels wrong");
  property p_off;
    @(posedge clk_sys) disable iff (rst) acc && avs_address == 4'h1 && op_reg == 8'h17 |=> ##[0:7] !field_on;
  endproperty
  a_off: assert property (p_off) else $error("field not switched off");
endmodule // rfc_core_chk
bind rfc_core rfc_core_chk #(.AW(AW)) u_rfc_core_chk (
  .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .field_on(field_on), .no_collision_avoid(no_collision_avoid), .active_mode(active_mode)
);

// file: rfc_host.sv
// Host model: Avalon-MM master issuing command and parameter words
`timescale 1ns/1ns
module rfc_host (
  input  wire        clk_sys,
  output reg  [3:0]  avs_address = 4'h0,
  output reg         avs_read = 1'b0,
  output reg         avs_write = 1'b0,
  output reg  [31:0] avs_writedata = 32'h0,
  input  wire [31:0] avs_readdata,
  input  wire        avs_waitrequest
);
  // One transfer, held until waitrequest is sampled low
  task acc(input rd, input [3:0] a, input [31:0] d, output [31:0] q);
    begin
      @(posedge clk_sys);
      avs_address   <= a;
      avs_read      <= rd;
      avs_write     <= !rd;
      avs_writedata <= d;
      @(posedge clk_sys);
      while (avs_waitrequest)
        @(posedge clk_sys);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
endmodule // rfc_host

// file: rf_config_and_testbus_commands_tb.sv
// Testbench for the settings and debug route engine
`timescale 1ns/1ns
`include "rfc_regs.vh"
module rf_config_and_testbus_commands_tb;
  reg         clk_sys = 1'b0;
  reg         rst = 1'b1;
  reg         rf_clk_div = 1'b1;
  reg  [3:0]  fn = 4'h0;
  reg  [7:0]  grp [0:6] = '{8'hA5, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
  reg  [7:0]  gcode [0:6] = '{8'h01, 8'h1B, 8'h1D, 8'h30, 8'h58, 8'h70, 8'h73};
  reg  [7:0]  sel [0:3] = '{8'h00, 8'h1C, 8'h80, 8'h9C};
  reg  [5:0]  cfg [0:3] = '{6'h00, 6'h1C, 6'h1D, 6'h39};
  reg  [31:0] ex [0:2] = '{32'h11223344, 32'hA1B2C3D4, 32'h5A000000};
  reg  [7:0]  bs [0:6] = '{8'h1D, 8'h7F, 8'h9D, 8'h00, 8'h00, 8'h00, 8'h00};
  reg  [7:0]  ba [0:6] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
  integer     bn [0:6] = '{1, 1, 1, 1, 0, 43, 0};
  integer     bx [0:6] = '{0, 0, 0, 0, 0, 0, 3};
  integer     errors = 0;
  integer     comparisons = 0;
  integer     cyc = 0;
  integer     i;
  reg  [31:0] q;
  wire [3:0]  avs_address;
  wire        avs_read, avs_write, avs_waitrequest;
  wire [31:0] avs_writedata, avs_readdata;
  wire        irq_pin, aux_pin_one, aux_pin_two, general_output_pin, field_on, no_collision_avoid, active_mode;
  always #5 clk_sys = ~clk_sys;
  rfc_core #(.AW(6)) u_rfc_core (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .clk_group_sig(grp[0]), .txenc_sig(grp[1]), .timer_sig(grp[2]), .card_sig(grp[3]), .trx_sig(grp[4]),
    .rxdata_sig(grp[5]), .rxerr_sig(grp[6]), .rf_clk_div(rf_clk_div), .irq_func(fn[3]), .aux_pin_one_func(fn[2]),
    .aux_pin_two_func(fn[1]), .gpo_func(fn[0]), .irq_pin(irq_pin), .aux_pin_one(aux_pin_one),
    .aux_pin_two(aux_pin_two), .general_output_pin(general_output_pin), .field_on(field_on),
    .no_collision_avoid(no_collision_avoid), .active_mode(active_mode));
  rfc_host u_rfc_host (
    .clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  task end_sim;
    begin
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    reg [31:0] t;
    begin
      u_rfc_host.acc(1'b0, a, d, t);
    end
  endtask
  task rd(input [3:0] a, output [31:0] t);
    begin
      u_rfc_host.acc(1'b1, a, 32'h0, t);
    end
  endtask
  task qry(input [7:0] op, input [7:0] b);
    begin
      wr(`RFC_ADDR_CMD, {24'h0, op});
      wr(`RFC_ADDR_DATA, {24'h0, b});
    end
  endtask
  // Poll data valid, then take one response word
  task get(output [31:0] t);
    integer n;
    begin
      n = 0;
      rd(`RFC_ADDR_STATUS, t);
      while (t[`RFC_ST_RDV] !== 1'b1 && n < 40) begin
        rd(`RFC_ADDR_STATUS, t);
        n = n + 1;
      end
      rd(`RFC_ADDR_DATA, t);
    end
  endtask
  task exc(input e, input string nm);
    reg [31:0] t;
    begin
      repeat (4) @(posedge clk_sys);
      rd(`RFC_ADDR_STATUS, t);
      chk(nm, t[`RFC_ST_EXC], e);
      wr(`RFC_ADDR_STATUS, 32'h19);
    end
  endtask
  // Entries of selector, address and four value bytes, then end mark
  task patch(input integer n, input [7:0] s, input [7:0] a, input [31:0] v, input integer xb);
    integer j;
    begin
      wr(`RFC_ADDR_CMD, {24'h0, `RFC_OP_PATCH});
      for (j = 0; j < 6 * n + xb; j = j + 1)
        wr(`RFC_ADDR_DATA, {24'h0, j % 6 == 0 ? s : j % 6 == 1 ? a : v[8 * (j % 6 - 2) +: 8]});
      wr(`RFC_ADDR_CMD, 32'h0);
    end
  endtask
  task rdcfg(input [7:0] s);
    reg [31:0] h;
    integer p;
    begin
      qry(`RFC_OP_COUNT, s);
      get(h);
      chk("size", h[7:0], 8'h03);
      qry(`RFC_OP_READ, s);
      for (p = 0; p < 3; p = p + 1) begin
        get(q);
        rd(`RFC_ADDR_DATA, h);
        chk("pair addr", q[7:0], p[7:0]);
        chk("pair data", {h[7:0], q[31:8]}, ex[p]);
      end
    end
  endtask
  task route(input [7:0] g, input integer n, input [31:0] pb);
    integer j;
    begin
      qry(`RFC_OP_ROUTE, g);
      for (j = 0; j < n; j = j + 1)
        wr(`RFC_ADDR_DATA, {24'h0, pb[8 * j +: 8]});
      wr(`RFC_ADDR_CMD, 32'h0);
      repeat (8) @(posedge clk_sys);
    end
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors = errors + 1;
      end_sim;
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`RFC_ADDR_STATUS, q);
    chk("status reset", q, 32'h0);
    rd(`RFC_ADDR_ALLOW, q);
    chk("allow reset", q, 32'h0);
    rd(4'h7, q);
    chk("unmapped", q, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`RFC_ADDR_SIZES, {18'h0, cfg[i], 8'h03});
      patch(1, sel[i], 8'h02, 32'h5A000000 + i, 0);
      exc(1'b0, "patch sel");
      qry(`RFC_OP_COUNT, sel[i]);
      get(q);
      chk("count", q[7:0], 8'h03);
    end
    patch(1, 8'h00, 8'h00, ex[0], 0);
    patch(1, 8'h00, 8'h01, ex[1], 0);
    patch(42, 8'h00, 8'h00, ex[0], 0);
    exc(1'b0, "patch 42");
    for (i = 0; i < 7; i = i + 1) begin
      patch(bn[i], bs[i], ba[i], ex[0], bx[i]);
      exc(1'b1, "patch bad");
    end
    rdcfg(8'h00);
    qry(`RFC_OP_COUNT, 8'h1D);
    exc(1'b1, "count sel");
    qry(`RFC_OP_READ, 8'h9D);
    exc(1'b1, "read sel");
    wr(`RFC_ADDR_CMD, {24'h0, `RFC_OP_RFU});
    exc(1'b0, "reserved op");
    for (i = 0; i < 4; i = i + 1) begin
      wr(`RFC_ADDR_ALLOW, i[0] ? 32'h0 : 32'h6);
      qry(`RFC_OP_FIELD_ON, i[7:0]);
      repeat (4) @(posedge clk_sys);
      rd(`RFC_ADDR_FIELD, q);
      chk("field reg", q[2:0], {i[1:0], 1'b1});
      chk("field pins", {active_mode, no_collision_avoid, field_on}, {i[1:0], 1'b1});
      rd(`RFC_ADDR_STATUS, q);
      chk("up flag", q[`RFC_ST_UP], !i[0]);
      qry(`RFC_OP_FIELD_OFF, 8'hC3 ^ i[7:0]);
      repeat (4) @(posedge clk_sys);
      rd(`RFC_ADDR_STATUS, q);
      chk("down flag", q[`RFC_ST_DOWN], !i[0]);
      chk("field off", field_on, 1'b0);
      wr(`RFC_ADDR_STATUS, 32'h19);
    end
    wr(`RFC_ADDR_ALLOW, 32'h1);
    route(8'h01, 4, 32'h38250712);
    chk("pins", {irq_pin, aux_pin_one, aux_pin_two, general_output_pin}, 4'hF);
    exc(1'b0, "route ok");
    route(8'h01, 2, 32'h00001949);
    chk("pins kept", {irq_pin, aux_pin_one, aux_pin_two, general_output_pin}, 4'hF);
    route(8'h01, 0, 32'h0);
    exc(1'b1, "route empty");
    @(posedge clk_sys);
    rf_clk_div <= 1'b0;
    grp[0] <= 8'h5A;
    repeat (8) @(posedge clk_sys);
    chk("pins live", {irq_pin, aux_pin_one, aux_pin_two, general_output_pin}, 4'h0);
    for (i = 0; i < 7; i = i + 1) begin
      grp[i] <= 8'h01 << i;
      route(gcode[i], 1, {28'h0, i[3:0]});
      chk("group on", irq_pin, 1'b1);
      grp[i] <= 8'h00;
      repeat (8) @(posedge clk_sys);
      chk("group off", irq_pin, 1'b0);
      grp[i] <= 8'hFF;
    end
    wr(`RFC_ADDR_ALLOW, 32'h0);
    @(posedge clk_sys);
    fn <= 4'hF;
    repeat (8) @(posedge clk_sys);
    chk("normal high", {irq_pin, aux_pin_one, aux_pin_two, general_output_pin}, 4'hF);
    fn <= 4'h0;
    repeat (8) @(posedge clk_sys);
    chk("normal low", {irq_pin, aux_pin_one, aux_pin_two, general_output_pin}, 4'h0);
    end_sim;
  end
endmodule // rf_config_and_testbus_commands_tb
